// file: core/lsft_pkg.sv
// Package for the line sensor frame timing block.
// Assumes a 1 MHz-derived microsecond tick made from the 50 MHz REF_CLK.
package lsft_pkg;
  localparam int          CLK_HZ        = 50000000;
  localparam int          US_PER_S      = 1000000;
  localparam int          TICK_CYCLES   = CLK_HZ / US_PER_S;
  localparam int          TICK_W        = 6;
  localparam int          T_READOUT_US  = 3710;
  localparam int          TIME_W        = 24;
  localparam logic [23:0] T_READOUT     = 24'h000e7e;
  localparam logic [23:0] T_INT_MIN     = 24'h00000a;
  localparam logic [23:0] T_INT_RESET   = 24'h001388;
  localparam logic [23:0] ONE_US        = 24'h000001;
  localparam logic [23:0] ZERO_US       = 24'h000000;
  localparam logic [9:0]  RPT_ONE       = 10'h001;

  typedef enum logic [1:0] {
    LSFT_ST_WAIT = 2'b00,
    LSFT_ST_RUN  = 2'b01,
    LSFT_ST_EXT  = 2'b10
  } lsft_state_e;

  typedef struct packed {
    logic frame_start;
    logic period_start;
    logic charge_clear;
    logic integrating;
    logic shutter;
  } lsft_strobe_s;
endpackage

// file: core/lsft_timing.sv
// Frame timing generator for a linear image sensor.
// Assumes REF_CLK at 50 MHz, trigger input asynchronous, integration value stable.
`timescale 1ns/1ns

// Behaviour
// - Integration at or above 3710 us selects non-shutter operation.
// - Non-shutter frame lasts exactly one integration period.
// - Non-shutter charge collection starts with the frame.
// - Integration below 3710 us selects shutter operation automatically.
// - Shutter frame is least multiple of period reaching 3710 us.
// - Charge cleared at start of every repeated shutter period.
// - Internal sync uses software integration value for frame timing.
// - External sync takes trigger interval as period and frame edges.
// - External sync only in externally synchronized mode.
// - Frames run back to back; readout overlaps next exposure.
// - Readout period fixed at 3710 us.
// - Integration values down to 10 us accepted via shutter.
module lsft_timing
  import lsft_pkg::*;
#(
  parameter int RPT_W = 10
) (
  input  wire logic               REF_CLK,
  input  wire logic               SYS_RST,
  input  wire logic [TIME_W-1:0]  INT_TIME_US,
  input  wire logic               EXT_SYNC_MODE,
  input  wire logic               TRIG_IN,
  output logic                    FRAME_START,
  output logic                    PERIOD_START,
  output logic                    CHARGE_CLEAR,
  output logic                    INTEGRATING,
  output logic                    SHUTTER_MODE,
  output logic                    READOUT_START,
  output logic [TIME_W-1:0]       PERIOD_US,
  output logic [RPT_W-1:0]        REPEAT_COUNT
);

  logic [TICK_W-1:0] tick_cnt_reg;
  logic              us_tick;
  logic [2:0]        trig_sync_reg;
  logic              trig_level_reg;
  logic              trig_rise;
  logic [TIME_W-1:0] t_int_clamped;
  logic [TIME_W-1:0] ext_meas_reg;
  logic [TIME_W-1:0] ext_period_reg;
  logic              ext_valid_reg;
  logic [TIME_W-1:0] period_sel;
  logic [TIME_W-1:0] us_cnt_reg;
  logic [RPT_W-1:0]  rpt_cnt_reg;
  logic [RPT_W-1:0]  rpt_target;
  logic              shutter_sel;
  logic              period_end;
  logic              frame_end;
  logic              frame_last;
  logic              cnt_restart;
  logic              ext_armed_reg;
  lsft_state_e       state_reg;
  lsft_state_e       state_next;
  lsft_strobe_s      strb_next;
  lsft_strobe_s      strb_reg;

  // Ceiling division by repeated subtraction would cost cycles; a divider is
  // fine here since the period only changes between frames.
  function automatic logic [RPT_W-1:0] ceil_div(input logic [TIME_W-1:0] num,
                                                input logic [TIME_W-1:0] den);
    logic [TIME_W-1:0] q;
    q = (num + den - ONE_US) / den;
    return q[RPT_W-1:0];
  endfunction

  assign us_tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

  // Change counts once second and third stages agree
  assign trig_rise = trig_sync_reg[1] & trig_sync_reg[2] & ~trig_level_reg;

  assign t_int_clamped = (INT_TIME_US < T_INT_MIN) ? T_INT_MIN : INT_TIME_US;
  assign period_sel    = EXT_SYNC_MODE ? ext_period_reg : t_int_clamped;
  assign shutter_sel   = (period_sel < T_READOUT);
  assign rpt_target    = shutter_sel ? ceil_div(T_READOUT, period_sel) : RPT_W'(RPT_ONE);
  assign period_end    = us_tick && (us_cnt_reg >= period_sel - ONE_US);
  assign frame_last    = (rpt_cnt_reg >= rpt_target - RPT_W'(RPT_ONE));
  assign frame_end     = period_end && frame_last;
  assign cnt_restart   = ((state_reg == LSFT_ST_RUN) && period_end) ||
                         ((state_reg == LSFT_ST_EXT) && trig_rise);

  always_comb begin
    state_next = state_reg;
    strb_next  = '0;
    strb_next.shutter = shutter_sel;
    unique case (state_reg)
      LSFT_ST_WAIT: begin
        if (EXT_SYNC_MODE && ext_valid_reg && trig_rise) begin
          state_next = LSFT_ST_EXT;
        end else if (!EXT_SYNC_MODE && us_tick) begin
          state_next = LSFT_ST_RUN;
        end
        if (state_next != LSFT_ST_WAIT) begin
          strb_next.frame_start  = 1'b1;
          strb_next.period_start = 1'b1;
          strb_next.charge_clear = shutter_sel;
          strb_next.integrating  = 1'b1;
        end
      end
      LSFT_ST_RUN: begin
        strb_next.integrating  = 1'b1;
        strb_next.frame_start  = frame_end;
        strb_next.period_start = period_end;
        strb_next.charge_clear = period_end && shutter_sel;
        if (EXT_SYNC_MODE) begin
          state_next = LSFT_ST_WAIT;
        end
      end
      LSFT_ST_EXT: begin
        // Trigger pulses mark both the frame edges and the period itself
        strb_next.integrating  = 1'b1;
        strb_next.frame_start  = trig_rise && frame_last;
        strb_next.period_start = trig_rise;
        strb_next.charge_clear = trig_rise && shutter_sel;
        if (!EXT_SYNC_MODE) begin
          state_next = LSFT_ST_WAIT;
        end
      end
      default: begin
        state_next = LSFT_ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= us_tick ? '0 : tick_cnt_reg + TICK_W'(1);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      trig_sync_reg  <= '0;
      trig_level_reg <= 1'b0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], TRIG_IN};
      if (trig_sync_reg[1] == trig_sync_reg[2]) begin
        trig_level_reg <= trig_sync_reg[2];
      end
    end
  end

  // Trigger interval measured in microseconds; relies on a steady trigger period
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ext_meas_reg   <= ZERO_US;
      ext_period_reg <= T_INT_RESET;
      ext_valid_reg  <= 1'b0;
    end else if (trig_rise) begin
      ext_meas_reg <= ZERO_US;
      if (ext_armed_reg && ext_meas_reg >= T_INT_MIN) begin
        ext_period_reg <= ext_meas_reg;
        ext_valid_reg  <= 1'b1;
      end
    end else if (us_tick && ext_meas_reg != {TIME_W{1'b1}}) begin
      ext_meas_reg <= ext_meas_reg + ONE_US;
    end
  end

  // First trigger after reset only opens a measurement; a partial count is dropped
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ext_armed_reg <= 1'b0;
    end else if (trig_rise) begin
      ext_armed_reg <= 1'b1;
    end
  end

  // Period counter; external mode restarts on each trigger
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || state_reg == LSFT_ST_WAIT) begin
      us_cnt_reg <= ZERO_US;
    end else if (cnt_restart) begin
      us_cnt_reg <= ZERO_US;
    end else if (us_tick) begin
      us_cnt_reg <= us_cnt_reg + ONE_US;
    end
  end

  // Repeat index wraps after the last period of a frame
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || state_reg == LSFT_ST_WAIT) begin
      rpt_cnt_reg <= '0;
    end else if (cnt_restart) begin
      rpt_cnt_reg <= frame_last ? '0 : rpt_cnt_reg + RPT_W'(1);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_reg     <= LSFT_ST_WAIT;
      strb_reg      <= '0;
      PERIOD_US     <= T_INT_RESET;
      REPEAT_COUNT  <= RPT_W'(RPT_ONE);
    end else begin
      state_reg     <= state_next;
      strb_reg      <= strb_next;
      PERIOD_US     <= period_sel;
      REPEAT_COUNT  <= rpt_target;
    end
  end

  // Integration starts together with the frame in non-shutter operation
  assign FRAME_START   = strb_reg.frame_start;
  assign READOUT_START = strb_reg.frame_start;
  assign PERIOD_START  = strb_reg.period_start;
  assign CHARGE_CLEAR  = strb_reg.charge_clear;
  assign INTEGRATING   = strb_reg.integrating;
  assign SHUTTER_MODE  = strb_reg.shutter;

endmodule

// file: tb/lsft_timing_properties.sv
// Port checker for lsft_timing.
// Assumes a bind to lsft_timing and one REF_CLK domain.
`timescale 1ns/1ns
module lsft_timing_chk
  import lsft_pkg::*;
#(
  parameter int RPT_W = 10
) (
  input wire logic              REF_CLK,
  input wire logic              SYS_RST,
  input wire logic [TIME_W-1:0] INT_TIME_US,
  input wire logic              EXT_SYNC_MODE,
  input wire logic              TRIG_IN,
  input wire logic              FRAME_START,
  input wire logic              PERIOD_START,
  input wire logic              CHARGE_CLEAR,
  input wire logic              INTEGRATING,
  input wire logic              SHUTTER_MODE,
  input wire logic              READOUT_START,
  input wire logic [TIME_W-1:0] PERIOD_US,
  input wire logic [RPT_W-1:0]  REPEAT_COUNT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  property p_sh; $stable(PERIOD_US) && INTEGRATING |-> SHUTTER_MODE == (PERIOD_US < T_READOUT); endproperty
  a_sh: assert property (p_sh) else $error("shutter mode wrong");
  property p_rc; $stable(PERIOD_US) && INTEGRATING |-> REPEAT_COUNT * PERIOD_US >= T_READOUT
    && (REPEAT_COUNT - 1) * PERIOD_US < T_READOUT; endproperty
  a_rc: assert property (p_rc) else $error("repeat count wrong");
  property p_fp; FRAME_START |-> PERIOD_START; endproperty
  a_fp: assert property (p_fp) else $error("frame without period");
  property p_ro; FRAME_START |-> READOUT_START; endproperty
  a_ro: assert property (p_ro) else $error("no readout at frame");
  property p_cc; PERIOD_START && SHUTTER_MODE |-> CHARGE_CLEAR; endproperty
  a_cc: assert property (p_cc) else $error("no charge clear");
  property p_ns; CHARGE_CLEAR |-> SHUTTER_MODE && PERIOD_START; endproperty
  a_ns: assert property (p_ns) else $error("stray charge clear");
  // Mode change restarts timing, so the window is dropped then
  property p_in; disable iff (SYS_RST || EXT_SYNC_MODE)
    PERIOD_START && PERIOD_US == 24'h00000a |=> !PERIOD_START[*8] ##[440:560] PERIOD_START; endproperty
  a_in: assert property (p_in) else $error("internal period spacing");
  property p_ex; EXT_SYNC_MODE && INTEGRATING && $rose(TRIG_IN) |-> ##[2:8] PERIOD_START; endproperty
  a_ex: assert property (p_ex) else $error("trigger not followed");
  property p_mn; INTEGRATING |-> PERIOD_US >= T_INT_MIN; endproperty
  a_mn: assert property (p_mn) else $error("period below minimum");
endmodule
bind lsft_timing lsft_timing_chk #(.RPT_W(RPT_W)) u_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .INT_TIME_US(INT_TIME_US), .EXT_SYNC_MODE(EXT_SYNC_MODE), .TRIG_IN(TRIG_IN),
  .FRAME_START(FRAME_START), .PERIOD_START(PERIOD_START), .CHARGE_CLEAR(CHARGE_CLEAR),
  .INTEGRATING(INTEGRATING), .SHUTTER_MODE(SHUTTER_MODE), .READOUT_START(READOUT_START),
  .PERIOD_US(PERIOD_US), .REPEAT_COUNT(REPEAT_COUNT));

// file: tb/lsft_trig_src.sv
// External trigger source model.
// Assumes the bench clock; period given in clock cycles.
`timescale 1ns/1ns
module lsft_trig_src (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic [15:0] per,
  output logic             trig
);
  logic [15:0] cnt_reg;
  always_ff @(posedge clk) begin
    cnt_reg <= (!en || cnt_reg == per - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
  end
  // Fixed period, 2 us high, idle low
  assign trig = en && (cnt_reg < 16'h0064);
endmodule

// file: tb/tb_lsft_timing.sv
// Self-checking bench for lsft_timing.
// Assumes lsft_pkg, the checker and the trigger model compiled first.
`timescale 1ns/1ns
module tb_lsft_timing;
  import lsft_pkg::*;
  typedef struct packed {logic [9:0] rc; logic sh; logic [23:0] p;} lsft_exp_s;
  logic REF_CLK = 1'b0, SYS_RST = 1'b1, EXT_SYNC_MODE = 1'b0, ext_en = 1'b0;
  logic [23:0] INT_TIME_US = 24'h001388;
  logic FRAME_START, PERIOD_START, CHARGE_CLEAR, INTEGRATING, SHUTTER_MODE, READOUT_START;
  logic TRIG_IN;
  logic [23:0] PERIOD_US;
  logic [9:0] REPEAT_COUNT;
  lsft_exp_s q[$];
  lsft_exp_s e;
  int mismatches = 0, checks = 0, n;
  always #10 REF_CLK = ~REF_CLK;
  lsft_trig_src u_src (.clk(REF_CLK), .en(ext_en), .per(16'h07d0), .trig(TRIG_IN));
  lsft_timing uut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .INT_TIME_US(INT_TIME_US),
    .EXT_SYNC_MODE(EXT_SYNC_MODE), .TRIG_IN(TRIG_IN), .FRAME_START(FRAME_START),
    .PERIOD_START(PERIOD_START), .CHARGE_CLEAR(CHARGE_CLEAR), .INTEGRATING(INTEGRATING),
    .SHUTTER_MODE(SHUTTER_MODE), .READOUT_START(READOUT_START), .PERIOD_US(PERIOD_US),
    .REPEAT_COUNT(REPEAT_COUNT));
  task automatic chk(string nm, logic [33:0] seen, logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Ceiling of readout over the clamped period
  function automatic lsft_exp_s ex_of(logic [23:0] t);
    logic [23:0] p;
    p = (t < T_INT_MIN) ? T_INT_MIN : t;
    ex_of.p = p;
    ex_of.sh = p < T_READOUT;
    ex_of.rc = 10'((T_READOUT + p - 24'h000001) / p);
  endfunction
  task automatic run(logic [23:0] t, logic x, int lim);
    @(posedge REF_CLK);
    SYS_RST <= 1'b1;
    INT_TIME_US <= t;
    EXT_SYNC_MODE <= x;
    ext_en <= x;
    repeat (12) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    q.push_back(ex_of(x ? 24'h000028 : t));
    n = 0;
    while (q.size() != 0 && n < lim) begin
      @(posedge REF_CLK);
      n++;
    end
    if (q.size() != 0) begin
      mismatches++;
      close_out();
    end
  endtask
  // Watcher pairs each frame start with the oldest note
  always @(posedge REF_CLK) begin
    if (FRAME_START === 1'b1) begin
      if (q.size() == 0) chk("spare frame", 34'h1, 34'h0);
      else begin
        e = q.pop_front();
        chk("repeat", REPEAT_COUNT, e.rc);
        chk("shutter", SHUTTER_MODE, e.sh);
        chk("period", PERIOD_US, e.p);
        chk("clear", CHARGE_CLEAR, e.sh);
        chk("readout", READOUT_START, 34'h1);
        chk("integrating", INTEGRATING, 34'h1);
        chk("period start", PERIOD_START, 34'h1);
      end
    end
  end
  initial begin
    logic [23:0] tv [9];
    n = $urandom(22);
    tv = '{24'h000003, 24'h0003e8, 24'h0007d0, 24'h000e7d, 24'h000e7e, 24'h001388,
      24'h0, 24'h0, 24'h00000a};
    tv[6] = 24'h00000a + 24'($urandom_range(3699));
    tv[7] = 24'h000e7e + 24'($urandom_range(2000));
    // Short limit also bounds the first frame delay
    foreach (tv[i]) run(tv[i], 1'b0, 150);
    // Let two 10 us periods pass so the spacing property completes
    repeat (1200) @(posedge REF_CLK);
    ext_en <= 1'b1;
    repeat (1500) @(posedge REF_CLK);
    run(24'h001388, 1'b1, 8000);
    close_out();
  end
endmodule
